/* src/wubm_batt_samp.sv */
// Battery converter result synchroniser and sleep-rate sampler
`timescale 1ns/1ps
module wubm_batt_samp #(
  parameter int UPD_TICKS = wubm_pkg::SLEEP_UPD_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic sleep_mode,
  input wire logic [4:0] level_in,
  output logic [4:0] level_q,
  output logic upd_q
);
  logic [4:0] s1_q, s2_q, s3_q;
  logic [15:0] sec_q;
  logic sec_hit;

  assign sec_hit = tick && (sec_q == 16'(UPD_TICKS - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
    end else begin
      s1_q <= level_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_q <= 16'h0000;
    end else if (sec_hit) begin
      sec_q <= 16'h0000;
    end else if (tick) begin
      sec_q <= sec_q + 16'h0001;
    end
  end

  // Converter code is taken only when two sync stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_q <= 5'h00;
      upd_q <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      if ((s2_q == s3_q) && (!sleep_mode || sec_hit)) begin // RULE_09
        level_q <= s3_q; // RULE_08
        upd_q <= 1'b1;
      end
    end
  end
endmodule // wubm_batt_samp

/* src/wubm_pkg.sv */
// Constants for the wake-up timer and battery monitor block
package wubm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PERIOD1 = 8'h14;
  localparam logic [7:0] IDX_MANT_HI = 8'h15;
  localparam logic [7:0] IDX_MANT_LO = 8'h16;
  localparam logic [7:0] IDX_CUR_HI = 8'h17;
  localparam logic [7:0] IDX_CUR_LO = 8'h18;
  localparam logic [7:0] IDX_ONWIN = 8'h19;
  localparam logic [7:0] IDX_BTHR = 8'h1a;
  localparam logic [7:0] IDX_BLVL = 8'h1b;
  localparam logic [7:0] IDX_CTRL = 8'h30;
  localparam logic [7:0] IDX_IRQ_ST = 8'h31;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h32;
  // Field positions
  localparam int EXP_R_LSB = 3;
  localparam int EXP_D_LSB = 0;
  localparam int CTRL_WAKE_EN = 0;
  localparam int CTRL_ONWIN_EN = 1;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_LOWBAT = 1;
  localparam int IRQ_ONWIN_END = 2;
  // Reset values
  localparam logic [2:0] EXP_R_RST = 3'h0;
  localparam logic [1:0] EXP_D_RST = 2'h0;
  localparam logic [15:0] MANT_RST = 16'h0001;
  localparam logic [7:0] ONWIN_RST = 8'h00;
  localparam logic [4:0] BTHR_RST = 5'h14;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] IRQ_MSK_RST = 3'h0;
  // Timing: base tick and mantissa step of 32 ticks
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int TICK_FREQ_HZ = 32_768;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / TICK_FREQ_HZ;
  localparam int MANT_STEP_TICKS = 32;
  localparam int SLEEP_UPD_S = 1;
  localparam int SLEEP_UPD_TICKS = SLEEP_UPD_S * TICK_FREQ_HZ;
endpackage

/* src/wubm_tick_gen.sv */
// Divider producing the one-cycle 32.768 kHz tick enable
`timescale 1ns/1ps
module wubm_tick_gen #(
  parameter int DIV = wubm_pkg::TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick_q
);
  logic [12:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 13'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q == 13'(DIV - 1)) begin
      cnt_q <= 13'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 13'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule // wubm_tick_gen

/* src/wubm_top.sv */
// Wake-up timer, on-window and low-battery monitor with AHB-Lite registers
//
// What this block does
// (RULE_01) The wake period is 32 x mantissa x 2^(R-D) ticks of 1/32.768 ms.
// (RULE_02) The 16-bit mantissa sits in a high byte resetting to 0 and a low byte resetting to 1.
// (RULE_03) The running mantissa count is readable as two read-only bytes.
// (RULE_04) The on-window lasts 32 x duration x 2^(R-D) ticks with the same exponents.
// (RULE_05) The on-window duration is an 8-bit read-write byte resetting to 0.
// (RULE_06) The low-battery flag is set whenever the battery level is below the threshold.
// (RULE_07) The threshold code means 1.7 V plus 50 mV per step and resets to 10100.
// (RULE_08) The battery level is a 5-bit result in bits 4..0, upper bits read zero.
// (RULE_09) The battery level refreshes once a second in sleep, continuously otherwise.
// (RULE_10) Exponent R is bits 5..3 and D bits 1..0 of the first period byte.
// (RULE_11) The wake counter runs on the 32.768 kHz tick, signals wake and restarts at zero.
// (RULE_12) After each wake the receiver stays on for the on-window, then goes back to sleep.
`timescale 1ns/1ps
module wubm_top #(
  parameter int TICK_DIV = wubm_pkg::TICK_CYCLES,
  parameter int SLEEP_TICKS = wubm_pkg::SLEEP_UPD_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_mode,
  input wire logic [4:0] batt_code,
  output logic wake_evt,
  output logic on_window_time,
  output logic irq
);
  logic [2:0] wtr_q;
  logic [1:0] wtd_q;
  logic [15:0] wtm_q;
  logic [7:0] ldc_q;
  logic [4:0] lbdt_q;
  logic [1:0] ctrl_q;
  logic [2:0] irq_st_q, irq_msk_q, irq_set;
  logic [12:0] pre_q;
  logic [15:0] mant_q;
  logic [7:0] on_q;
  logic on_win_q, wake_q, irq_q;
  logic tick, run, pre_wrap, wake, on_end;
  logic [4:0] blvl;
  logic blvl_upd;
  logic wr_pend_q, rd_pend_q, hready_q;
  logic [7:0] widx_q, ridx_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic [7:0] aidx;
  logic [12:0] presc;

  // Mantissa step in ticks: 32 shifted by R then D
  function automatic logic [12:0] step_ticks(input logic [2:0] r, input logic [1:0] d);
    step_ticks = (13'(wubm_pkg::MANT_STEP_TICKS) << r) >> d;
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] idx, input logic [15:0] cur);
    rd_mux = 32'h0000_0000;
    unique case (idx)
      wubm_pkg::IDX_PERIOD1: rd_mux[5:0] = {wtr_q, 1'b0, wtd_q};
      wubm_pkg::IDX_MANT_HI: rd_mux[7:0] = wtm_q[15:8];
      wubm_pkg::IDX_MANT_LO: rd_mux[7:0] = wtm_q[7:0];
      wubm_pkg::IDX_CUR_HI: rd_mux[7:0] = cur[15:8];
      wubm_pkg::IDX_CUR_LO: rd_mux[7:0] = cur[7:0];
      wubm_pkg::IDX_ONWIN: rd_mux[7:0] = ldc_q;
      wubm_pkg::IDX_BTHR: rd_mux[4:0] = lbdt_q;
      wubm_pkg::IDX_BLVL: rd_mux[4:0] = blvl;
      wubm_pkg::IDX_CTRL: rd_mux[1:0] = ctrl_q;
      wubm_pkg::IDX_IRQ_ST: rd_mux[2:0] = irq_st_q;
      wubm_pkg::IDX_IRQ_MSK: rd_mux[2:0] = irq_msk_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  wubm_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_q(tick)
  );

  wubm_batt_samp #(.UPD_TICKS(SLEEP_TICKS)) u_batt (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .sleep_mode(sleep_mode),
    .level_in(batt_code),
    .level_q(blvl),
    .upd_q(blvl_upd)
  );

  // Bus slave: writes take no wait state, reads take one
  assign aidx = haddr[9:2];
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      widx_q <= 8'h00;
      ridx_q <= 8'h00;
    end else begin
      if (hready) begin
        wr_pend_q <= addr_ok && hwrite;
        widx_q <= aidx;
      end
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok && !hwrite) begin
        ridx_q <= aidx;
      end
    end
  end

  // The wait state lets a write in the preceding data phase land before the read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hready_q <= 1'b0;
    end else if (rd_pend_q) begin
      hready_q <= 1'b1;
      hrdata_q <= rd_mux(ridx_q, mant_q); // RULE_03 RULE_08
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wtr_q <= wubm_pkg::EXP_R_RST;
      wtd_q <= wubm_pkg::EXP_D_RST;
      wtm_q <= wubm_pkg::MANT_RST;
      ldc_q <= wubm_pkg::ONWIN_RST;
      lbdt_q <= wubm_pkg::BTHR_RST;
      ctrl_q <= wubm_pkg::CTRL_RST;
      irq_msk_q <= wubm_pkg::IRQ_MSK_RST;
    end else if (wr_pend_q) begin
      unique case (widx_q)
        wubm_pkg::IDX_PERIOD1: begin
          wtr_q <= hwdata[wubm_pkg::EXP_R_LSB +: 3]; // RULE_10
          wtd_q <= hwdata[wubm_pkg::EXP_D_LSB +: 2]; // RULE_10
        end
        wubm_pkg::IDX_MANT_HI: wtm_q[15:8] <= hwdata[7:0]; // RULE_02
        wubm_pkg::IDX_MANT_LO: wtm_q[7:0] <= hwdata[7:0]; // RULE_02
        wubm_pkg::IDX_ONWIN: ldc_q <= hwdata[7:0]; // RULE_05
        wubm_pkg::IDX_BTHR: lbdt_q <= hwdata[4:0]; // RULE_07
        wubm_pkg::IDX_CTRL: ctrl_q <= hwdata[1:0];
        wubm_pkg::IDX_IRQ_MSK: irq_msk_q <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // Wake timer: prescaler of 32*2^(R-D) ticks, then mantissa count
  assign presc = step_ticks(wtr_q, wtd_q); // RULE_01 RULE_10
  assign run = ctrl_q[wubm_pkg::CTRL_WAKE_EN] && (wtm_q != 16'h0000);
  assign pre_wrap = run && tick && (pre_q >= presc - 13'h0001);
  assign wake = pre_wrap && (mant_q >= wtm_q - 16'h0001); // RULE_01

  // A zero mantissa would give a zero period, so it halts the timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 13'h0000;
      mant_q <= 16'h0000;
    end else if (!run) begin
      pre_q <= 13'h0000;
      mant_q <= 16'h0000;
    end else if (wake) begin
      pre_q <= 13'h0000; // RULE_11
      mant_q <= 16'h0000; // RULE_11
    end else if (pre_wrap) begin
      pre_q <= 13'h0000;
      mant_q <= mant_q + 16'h0001;
    end else if (tick) begin
      pre_q <= pre_q + 13'h0001; // RULE_11
    end
  end

  // On-window: counted in mantissa steps from the wake that opened it
  assign on_end = on_win_q && !wake && pre_wrap && (on_q >= ldc_q - 8'h01); // RULE_04

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_win_q <= 1'b0;
      on_q <= 8'h00;
    end else if (wake) begin
      on_win_q <= ctrl_q[wubm_pkg::CTRL_ONWIN_EN] && (ldc_q != 8'h00); // RULE_12
      on_q <= 8'h00;
    end else if (on_end || !run) begin
      on_win_q <= 1'b0; // RULE_12
      on_q <= 8'h00;
    end else if (on_win_q && pre_wrap) begin
      on_q <= on_q + 8'h01; // RULE_04
    end
  end

  assign on_window_time = on_win_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake;
    end
  end

  assign wake_evt = wake_q;

  // Events; a set in the same cycle as the read wins over the clear
  always_comb begin
    irq_set = 3'h0;
    irq_set[wubm_pkg::IRQ_WAKE] = wake;
    irq_set[wubm_pkg::IRQ_LOWBAT] = blvl < lbdt_q; // RULE_06
    irq_set[wubm_pkg::IRQ_ONWIN_END] = on_end;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= 3'h0;
    end else if (rd_pend_q && (ridx_q == wubm_pkg::IDX_IRQ_ST)) begin
      irq_st_q <= irq_set; // RULE_06
    end else begin
      irq_st_q <= irq_st_q | irq_set; // RULE_06
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_q & irq_msk_q);
    end
  end

  assign irq = irq_q;

  property p_wake_restart;
    @(posedge hclk) disable iff (!hresetn)
    wake |=> (mant_q == 16'h0000) && (pre_q == 13'h0000);
  endproperty
  a_wake_restart: assert property (p_wake_restart) // RULE_11
    else $error("wake counter did not restart at zero");

  property p_pre_bound;
    @(posedge hclk) disable iff (!hresetn)
    run && (pre_q < presc) |=> (pre_q < presc) || $changed(presc);
  endproperty
  a_pre_bound: assert property (p_pre_bound) // RULE_01
    else $error("prescaler passed its 32*2^(R-D) step");

  property p_mant_bound;
    @(posedge hclk) disable iff (!hresetn)
    run && (mant_q < wtm_q) |=> (mant_q < wtm_q) || $changed(wtm_q);
  endproperty
  a_mant_bound: assert property (p_mant_bound) // RULE_01
    else $error("mantissa count reached the programmed mantissa");

  property p_evt_out;
    @(posedge hclk) disable iff (!hresetn)
    wake |=> wake_evt ##1 !wake_evt;
  endproperty
  a_evt_out: assert property (p_evt_out) // RULE_11
    else $error("wake event output not a one-cycle pulse");

  property p_win_open;
    @(posedge hclk) disable iff (!hresetn)
    wake && ctrl_q[wubm_pkg::CTRL_ONWIN_EN] && (ldc_q != 8'h00) |=> on_window_time;
  endproperty
  a_win_open: assert property (p_win_open) // RULE_12
    else $error("on-window did not open after wake");

  property p_win_close;
    @(posedge hclk) disable iff (!hresetn)
    $fell(on_win_q) |-> $past(on_end) || !$past(run) || $past(wake);
  endproperty
  a_win_close: assert property (p_win_close) // RULE_04
    else $error("on-window closed before its duration");

  property p_lowbat;
    @(posedge hclk) disable iff (!hresetn)
    (blvl < lbdt_q) |=> irq_st_q[wubm_pkg::IRQ_LOWBAT];
  endproperty
  a_lowbat: assert property (p_lowbat) // RULE_06
    else $error("low-battery flag missing");

  property p_cur_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_pend_q && (ridx_q == wubm_pkg::IDX_CUR_LO) |=> hreadyout
      && (hrdata[7:0] == $past(mant_q[7:0])) && (hrdata[31:8] == 24'h00_0000);
  endproperty
  a_cur_read: assert property (p_cur_read) // RULE_03
    else $error("running mantissa readback wrong");

  property p_lvl_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_pend_q && (ridx_q == wubm_pkg::IDX_BLVL) |=> hrdata[31:5] == 27'h000_0000;
  endproperty
  a_lvl_read: assert property (p_lvl_read) // RULE_08
    else $error("battery level upper bits not zero");

  property p_irq_out;
    @(posedge hclk) disable iff (!hresetn)
    |(irq_st_q & irq_msk_q) |=> irq;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt output not raised");

  property p_rd_wait;
    @(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read did not take exactly one wait state");

  property p_status_clear;
    @(posedge hclk) disable iff (!hresetn)
    rd_pend_q && (ridx_q == wubm_pkg::IDX_IRQ_ST) |=> irq_st_q == $past(irq_set);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status read did not clear to the new events");

  property p_win_step;
    @(posedge hclk) disable iff (!hresetn)
    on_win_q && pre_wrap && !wake && !on_end
      |=> on_window_time && (on_q == $past(on_q) + 8'h01);
  endproperty
  a_win_step: assert property (p_win_step) // RULE_04
    else $error("on-window step count wrong");

  property p_lvl_chg;
    @(posedge hclk) disable iff (!hresetn)
    $changed(blvl) |-> blvl_upd;
  endproperty
  a_lvl_chg: assert property (p_lvl_chg) // RULE_08
    else $error("battery level changed without an update");

  property p_sleep_upd;
    @(posedge hclk) disable iff (!hresetn)
    blvl_upd && $past(sleep_mode) |-> $past(tick);
  endproperty
  a_sleep_upd: assert property (p_sleep_upd) // RULE_09
    else $error("battery level refreshed off the sleep interval");

  c_wake: cover property (@(posedge hclk) disable iff (!hresetn) wake ##[1:1000] wake);
  c_window: cover property (@(posedge hclk) disable iff (!hresetn) $fell(on_win_q));
  c_lowbat: cover property (@(posedge hclk) disable iff (!hresetn) blvl_upd && irq);
endmodule // wubm_top

/* test/wubm_top_tb.sv */
// Self-checking bench for the wake-up timer and battery monitor over AHB-Lite
`timescale 1ns/1ps
module wubm_top_tb;
  localparam int DIV = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic sleep_mode = 1'b0;
  logic [4:0] batt_code = 5'h1f;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic wake_evt;
  logic on_window_time;
  logic irq;
  logic [31:0] x;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int last_wake = 0;
  int gap = 0;
  int nwake = 0;
  int on_cnt = 0;
  int on_len = 0;
  int rs[4] = '{0, 2, 0, 5};
  int ds[4] = '{0, 0, 3, 3};
  int step;

  always #5 hclk = ~hclk;

  // Small divider and sleep interval keep the run short
  wubm_top #(.TICK_DIV(DIV), .SLEEP_TICKS(8)) dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .sleep_mode(sleep_mode),
    .batt_code(batt_code),
    .wake_evt(wake_evt),
    .on_window_time(on_window_time),
    .irq(irq)
  );

  // Sampled at the falling edge so outputs are settled
  always @(negedge hclk) begin
    cyc <= cyc + 1;
    if (wake_evt === 1'b1) begin
      gap <= cyc - last_wake;
      last_wake <= cyc;
      nwake <= nwake + 1;
    end
    if (on_window_time === 1'b1) on_cnt <= on_cnt + 1;
    else if (on_cnt != 0) begin
      on_len <= on_cnt;
      on_cnt <= 0;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("BAD %0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  // Ready is judged at the falling edge, which equals sampling it at the next rising edge
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic rdy, rsp;
    int n;
    haddr <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    for (n = 0; n < 2; n++) begin
      rdy = 1'b0;
      for (int k = 0; k < 20 && rdy !== 1'b1; k++) begin
        @(negedge hclk);
        rdy = hreadyout;
        rd = hrdata;
        rsp = hresp;
        @(posedge hclk);
      end
      chk({31'h0000_0000, rdy}, 32'h0000_0001, "bus ready");
      chk({31'h0000_0000, rsp}, 32'h0000_0000, "bus okay");
      if (n == 0) begin
        htrans <= 2'b00;
        hwdata <= wd;
      end
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] y;
    bus(idx, 1'b1, d, y);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] e, input string what);
    logic [31:0] y;
    bus(idx, 1'b0, 32'h0000_0000, y);
    chk(y, e, what);
  endtask

  // The irq flop lags status and mask by one edge
  task automatic chk_irq(input logic e);
    @(posedge hclk);
    @(negedge hclk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, e}, "irq level");
    @(posedge hclk);
  endtask

  task automatic wait_wakes(input int n);
    int s;
    s = nwake;
    for (int k = 0; k < 30000 && nwake < s + n; k++) @(posedge hclk);
    chk_rng(nwake - s, n, 1000, "wake count");
  endtask

  // Polling catches a refresh within one read, three cycles
  task automatic poll_lvl(input logic [4:0] e);
    logic [31:0] y;
    y = 32'h0000_0000;
    for (int k = 0; k < 80 && y !== 32'(e); k++) bus(wubm_pkg::IDX_BLVL, 1'b0, 32'h0000_0000, y);
    chk(y, 32'(e), "battery level refresh");
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #600_000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    rdc(wubm_pkg::IDX_MANT_HI, 32'h0000_0000, "mant hi reset");
    rdc(wubm_pkg::IDX_MANT_LO, 32'h0000_0001, "mant lo reset");
    rdc(wubm_pkg::IDX_ONWIN, 32'h0000_0000, "duration reset");
    rdc(wubm_pkg::IDX_BTHR, 32'h0000_0014, "threshold reset");
    rdc(wubm_pkg::IDX_PERIOD1, 32'h0000_0000, "period1 reset");
    rdc(wubm_pkg::IDX_CUR_HI, 32'h0000_0000, "count hi halted");
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0000_0000, "unmapped");
    bus(wubm_pkg::IDX_IRQ_ST, 1'b0, 32'h0000_0000, x);
    wr(wubm_pkg::IDX_PERIOD1, 32'hffff_ffff);
    rdc(wubm_pkg::IDX_PERIOD1, 32'h0000_003b, "period1 fields");
    wr(wubm_pkg::IDX_BTHR, 32'hffff_ffff);
    rdc(wubm_pkg::IDX_BTHR, 32'h0000_001f, "threshold field");
    wr(wubm_pkg::IDX_ONWIN, 32'hffff_ffa5);
    rdc(wubm_pkg::IDX_ONWIN, 32'h0000_00a5, "duration rw");
    wr(wubm_pkg::IDX_MANT_HI, 32'h0000_005a);
    wr(wubm_pkg::IDX_MANT_LO, 32'h0000_00c3);
    rdc(wubm_pkg::IDX_MANT_HI, 32'h0000_005a, "mant hi rw");
    rdc(wubm_pkg::IDX_MANT_LO, 32'h0000_00c3, "mant lo rw");
    wr(wubm_pkg::IDX_CUR_LO, 32'h0000_00ff);
    rdc(wubm_pkg::IDX_CUR_LO, 32'h0000_0000, "count lo read-only");
    wr(wubm_pkg::IDX_BLVL, 32'h0000_0000);
    rdc(wubm_pkg::IDX_BLVL, 32'h0000_001f, "level read-only");
    wr(wubm_pkg::IDX_BTHR, 32'h0000_0014);
    wr(wubm_pkg::IDX_MANT_HI, 32'h0000_0000);
    wr(wubm_pkg::IDX_MANT_LO, 32'h0000_0003);
    wr(wubm_pkg::IDX_ONWIN, 32'h0000_0002);
    // Exponents above and below each other, period M=3, window two steps
    for (int i = 0; i < 4; i++) begin
      step = (32 << rs[i]) >> ds[i];
      wr(wubm_pkg::IDX_PERIOD1, 32'((rs[i] << 3) | ds[i]));
      wr(wubm_pkg::IDX_CTRL, 32'h0000_0003);
      wait_wakes(3);
      chk_rng(gap, 3 * step * DIV, 3 * step * DIV, "wake period");
      chk_rng(on_len, 2 * step * DIV, 2 * step * DIV, "on window");
    end
    wr(wubm_pkg::IDX_CTRL, 32'h0000_0000);
    rdc(wubm_pkg::IDX_IRQ_ST, 32'h0000_0005, "wake and window status");
    rdc(wubm_pkg::IDX_IRQ_ST, 32'h0000_0000, "status read clears");
    // Running count with M=256 and a step of 16 cycles
    wr(wubm_pkg::IDX_MANT_HI, 32'h0000_0001);
    wr(wubm_pkg::IDX_MANT_LO, 32'h0000_0000);
    wr(wubm_pkg::IDX_PERIOD1, 32'h0000_0003);
    wr(wubm_pkg::IDX_CTRL, 32'h0000_0001);
    repeat (160) @(posedge hclk);
    bus(wubm_pkg::IDX_CUR_LO, 1'b0, 32'h0000_0000, x);
    chk_rng(int'(x), 8, 11, "running count");
    rdc(wubm_pkg::IDX_CUR_HI, 32'h0000_0000, "running count hi");
    // Halt first: shrinking M under a larger count would wake at the next step, not after a full period
    wr(wubm_pkg::IDX_CTRL, 32'h0000_0000);
    wr(wubm_pkg::IDX_MANT_HI, 32'h0000_0000);
    wr(wubm_pkg::IDX_MANT_LO, 32'h0000_0001);
    wr(wubm_pkg::IDX_CTRL, 32'h0000_0001);
    wait_wakes(1);
    wr(wubm_pkg::IDX_CTRL, 32'h0000_0000);
    chk_irq(1'b0);
    wr(wubm_pkg::IDX_IRQ_MSK, 32'h0000_0007);
    chk_irq(1'b1);
    rdc(wubm_pkg::IDX_IRQ_ST, 32'h0000_0001, "wake status");
    chk_irq(1'b0);
    batt_code <= 5'h14;
    repeat (10) @(posedge hclk);
    rdc(wubm_pkg::IDX_IRQ_ST, 32'h0000_0000, "level equal threshold");
    batt_code <= 5'h13;
    repeat (10) @(posedge hclk);
    rdc(wubm_pkg::IDX_BLVL, 32'h0000_0013, "level tracks");
    chk_irq(1'b1);
    rdc(wubm_pkg::IDX_IRQ_ST, 32'h0000_0002, "low battery");
    rdc(wubm_pkg::IDX_IRQ_ST, 32'h0000_0002, "low battery again");
    batt_code <= 5'h19;
    repeat (10) @(posedge hclk);
    bus(wubm_pkg::IDX_IRQ_ST, 1'b0, 32'h0000_0000, x);
    rdc(wubm_pkg::IDX_IRQ_ST, 32'h0000_0000, "battery recovered");
    chk_irq(1'b0);
    wr(wubm_pkg::IDX_BTHR, 32'h0000_001a);
    repeat (4) @(posedge hclk);
    rdc(wubm_pkg::IDX_IRQ_ST, 32'h0000_0002, "raised threshold");
    // In sleep a change right after a refresh must stay hidden until the next one
    sleep_mode <= 1'b1;
    batt_code <= 5'h09;
    poll_lvl(5'h09);
    batt_code <= 5'h0c;
    rdc(wubm_pkg::IDX_BLVL, 32'h0000_0009, "sleep level held");
    poll_lvl(5'h0c);
    give_verdict;
  end
endmodule // wubm_top_tb
